/* File: rps_pkg.sv */
/*
 * Constants shared by the packet sniffer output block: register
 * addresses, field positions, reset values, pin function codes,
 * sniffer clock timing and the serializer state encoding.
 * Assumes a 100 MHz system clock and byte-wide register access.
 */
package rps_pkg;

    // ------------------------------------------------------------
    // Register addresses (byte addresses in the 7-bit space)
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_PIN0_FN    = 7'h20; // pin0_function_select
    localparam logic [6:0] ADDR_PIN4_FN    = 7'h24; // pin4_function_select
    localparam logic [6:0] ADDR_MDM_TEST_B = 7'h5B; // modem_test_control_b
    localparam int         PIN_COUNT       = 6;     // Configurable pins

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int         SNIFF_EN_BIT     = 2;     // Sniffer enable bit
    localparam logic [7:0] PIN_FN_RESET     = 8'h00; // Pin function reset
    localparam logic [7:0] MDM_TEST_B_RESET = 8'h00; // Test reg reset

    // Pin function codes
    localparam logic [7:0] FN_SNIFF_CLK  = 8'h31; // Sniffer clock out
    localparam logic [7:0] FN_SNIFF_DATA = 8'h32; // Sniffer data out
    localparam logic [7:0] FN_SFD        = 8'h33; // Frame delimiter out

    // Marker byte that replaces each generated CRC byte
    localparam logic [7:0] CRC_MARK_BYTE = 8'h80;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ    = 100_000_000;             // System clock
    localparam int SNIFF_HZ  = 250_000;                 // Sniffer clock
    localparam int HALF_CYC  = CLK_HZ / (2 * SNIFF_HZ); // Half period
    localparam int HALF_W    = 8;                       // Counter width
    localparam int BYTE_W    = 8;                       // Byte width
    localparam int FIFO_DEPTH = 8;                      // Byte buffer

    // Serializer states
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00, // Clock low, data low
        SER_LOW  = 2'b01, // Clock low half
        SER_HIGH = 2'b10  // Clock high half
    } rps_ser_state_t;

endpackage : rps_pkg

/* File: rps_tick.sv */
/*
 * Restartable divider: one-cycle enable pulse every LIMIT cycles
 * while run is high; the count restarts whenever run is low.
 * Assumes run comes from logic on the same clock.
 */
module rps_tick #(
    parameter int LIMIT = 200, // Cycles between pulses
    parameter int CW    = 8    // Counter width
) (
    input  wire logic mclk, // System clock
    input  wire logic nrst, // Async reset, active low
    input  wire logic run,  // Count while high
    output logic      tick  // Pulse on last cycle of each period
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CW-1:0] cnt; // Cycle count within period
    } rps_tick_st_t;

    rps_tick_st_t st_q; // Registered state
    rps_tick_st_t st_d; // Next state

    // Count and wrap
    always_comb begin
        st_d = st_q;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == CW'(LIMIT - 1)) begin
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = run && (st_q.cnt == CW'(LIMIT - 1));

endmodule : rps_tick

/* File: rps_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes both sides run on mclk; read data comes from the array.
 */
module rps_fifo #(
    parameter int W = 8, // Word width
    parameter int D = 8  // Depth in words
) (
    input  wire logic         mclk,     // System clock
    input  wire logic         nrst,     // Async reset, active low
    input  wire logic         flush,    // Drop all contents
    input  wire logic         wr_valid, // Write request
    output logic              wr_ready, // Not full
    input  wire logic [W-1:0] wr_data,  // Write word
    output logic              rd_valid, // Not empty
    input  wire logic         rd_ready, // Pop head word
    output logic      [W-1:0] rd_data   // Head word
);

    localparam int AW = $clog2(D);     // Pointer width
    localparam int CW = $clog2(D + 1); // Fill count width

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [D-1:0][W-1:0] mem; // Storage
        logic [AW-1:0]       wp;  // Write pointer
        logic [AW-1:0]       rp;  // Read pointer
        logic [CW-1:0]       cnt; // Fill level
    } rps_fifo_st_t;

    rps_fifo_st_t st_q; // Registered state
    rps_fifo_st_t st_d; // Next state
    logic         push; // Accepted write
    logic         pop;  // Accepted read

    assign wr_ready = (st_q.cnt != CW'(D));
    assign rd_valid = (st_q.cnt != '0);
    assign rd_data  = st_q.mem[st_q.rp];
    assign push     = wr_valid && wr_ready && !flush;
    assign pop      = rd_ready && rd_valid && !flush;

    // Pointer and level update
    always_comb begin
        st_d = st_q;
        if (flush) begin
            st_d.wp  = '0;
            st_d.rp  = '0;
            st_d.cnt = '0;
        end else begin
            if (push) begin
                st_d.mem[st_q.wp] = wr_data;
                st_d.wp           = (st_q.wp == AW'(D - 1)) ? '0 : st_q.wp + 1'b1;
            end
            if (pop) begin
                st_d.rp = (st_q.rp == AW'(D - 1)) ? '0 : st_q.rp + 1'b1;
            end
            st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : rps_fifo

/* File: rps_sniffer.sv */
/*
 * Packet sniffer output: captures radio bytes passively, buffers
 * them and shifts them out MSB first on a 250 kHz clock routed to
 * six configurable pins, with byte-wide register access.
 * Assumes modem byte strobes and register strobes are on mclk.
 */
module rps_sniffer (
    input  wire logic       mclk,          // System clock, 100 MHz
    input  wire logic       nrst,          // Async reset, active low
    input  wire logic [6:0] reg_addr,      // Register byte address
    input  wire logic [7:0] reg_wdata,     // Register write data
    input  wire logic       reg_we,        // Register write strobe
    input  wire logic       reg_re,        // Register read strobe
    output logic      [7:0] reg_rdata,     // Register read data
    input  wire logic       tx_byte_valid, // Modulator fetched a byte
    input  wire logic [7:0] tx_byte,       // Fetched byte
    input  wire logic       tx_crc_valid,  // Modulator sent a CRC byte
    input  wire logic       tx_auto_crc,   // Automatic CRC enabled
    input  wire logic       rx_byte_valid, // Demodulator stored a byte
    input  wire logic [7:0] rx_byte,       // Stored byte
    input  wire logic       sfd,           // Frame delimiter level
    output logic      [5:0] pin_out,       // Pin output levels
    output logic      [5:0] pin_oe,        // Pin output enables
    output logic            sniff_ready    // Buffer has room
);

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0][7:0]         fn;     // Pin function selects
        logic [7:0]              mtest;  // modem_test_control_b
        logic [7:0]              rdata;  // Read data register
        rps_pkg::rps_ser_state_t state;  // Serializer state
        logic [7:0]              shreg;  // Shift register
        logic [2:0]              bitcnt; // Bits sent in byte
        logic                    sclk;   // Sniffer clock
        logic                    sdata;  // Sniffer data
        logic [5:0]              pout;   // Pin levels
        logic [5:0]              poe;    // Pin enables
    } rps_st_t;

    rps_st_t    st_q;     // Registered state
    rps_st_t    st_d;     // Next state
    logic       en;       // Sniffer enabled
    logic       wr_valid; // Byte into buffer
    logic [7:0] wr_data;  // Buffered byte
    logic       rd_valid; // Buffer not empty
    logic       rd_ready; // Serializer pops
    logic [7:0] rd_data;  // Buffer head
    logic       tick;     // Half-period pulse
    logic [5:0] mux_out;  // Per-pin selected level
    logic [5:0] mux_oe;   // Per-pin enable

    assign en = st_q.mtest[rps_pkg::SNIFF_EN_BIT];

    // ------------------------------------------------------------
    // Capture: taps only, nothing flows back to the modem
    // ------------------------------------------------------------
    always_comb begin
        wr_valid = 1'b0;
        wr_data  = rx_byte;
        if (en && tx_crc_valid && tx_auto_crc) begin
            wr_valid = 1'b1;
            wr_data  = rps_pkg::CRC_MARK_BYTE;
        end else if (en && tx_byte_valid) begin
            wr_valid = 1'b1;
            wr_data  = tx_byte;
        end else if (en && rx_byte_valid) begin
            wr_valid = 1'b1;
        end
    end

    // Byte buffer, flushed while disabled
    rps_fifo #(
        .W (rps_pkg::BYTE_W),
        .D (rps_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .nrst     (nrst),
        .flush    (!en),
        .wr_valid (wr_valid),
        .wr_ready (sniff_ready),
        .wr_data  (wr_data),
        .rd_valid (rd_valid),
        .rd_ready (rd_ready),
        .rd_data  (rd_data)
    );

    // Half-period divider for the sniffer clock
    rps_tick #(
        .LIMIT (rps_pkg::HALF_CYC),
        .CW    (rps_pkg::HALF_W)
    ) u_tick (
        .mclk (mclk),
        .nrst (nrst),
        .run  (st_q.state != rps_pkg::SER_IDLE),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // Pin function mux, one per pin
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < rps_pkg::PIN_COUNT; i++) begin : g_pin
            always_comb begin
                mux_out[i] = 1'b0;
                mux_oe[i]  = 1'b1;
                case (st_q.fn[i])
                    rps_pkg::FN_SNIFF_CLK: begin
                        mux_out[i] = en && st_q.sclk;
                    end
                    rps_pkg::FN_SNIFF_DATA: begin
                        mux_out[i] = en && st_q.sdata;
                    end
                    rps_pkg::FN_SFD: begin
                        mux_out[i] = sfd;
                    end
                    default: begin
                        mux_oe[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers, serializer and pin staging
    // ------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        rd_ready  = 1'b0;
        st_d.pout = mux_out;
        st_d.poe  = mux_oe;
        // Register writes
        if (reg_we) begin
            for (int i = 0; i < rps_pkg::PIN_COUNT; i++) begin
                if (reg_addr == rps_pkg::ADDR_PIN0_FN + 7'(i)) begin
                    st_d.fn[i] = reg_wdata;
                end
            end
            if (reg_addr == rps_pkg::ADDR_MDM_TEST_B) begin
                st_d.mtest = reg_wdata;
            end
        end
        // Register reads; unmapped reads as zero
        if (reg_re) begin
            st_d.rdata = 8'h00;
            for (int i = 0; i < rps_pkg::PIN_COUNT; i++) begin
                if (reg_addr == rps_pkg::ADDR_PIN0_FN + 7'(i)) begin
                    st_d.rdata = st_q.fn[i];
                end
            end
            if (reg_addr == rps_pkg::ADDR_MDM_TEST_B) begin
                st_d.rdata = st_q.mtest;
            end
        end
        // Serializer
        case (st_q.state)
            rps_pkg::SER_IDLE: begin
                st_d.sclk  = 1'b0;
                st_d.sdata = 1'b0;
                if (en && rd_valid) begin
                    rd_ready    = 1'b1;
                    st_d.shreg  = rd_data;
                    st_d.sdata  = rd_data[7];
                    st_d.bitcnt = 3'h0;
                    st_d.state  = rps_pkg::SER_LOW;
                end
            end
            rps_pkg::SER_LOW: begin
                if (tick) begin
                    st_d.sclk  = 1'b1;
                    st_d.state = rps_pkg::SER_HIGH;
                end
            end
            rps_pkg::SER_HIGH: begin
                if (tick) begin
                    st_d.sclk = 1'b0;
                    if (st_q.bitcnt != 3'h7) begin
                        st_d.shreg  = {st_q.shreg[6:0], 1'b0};
                        st_d.sdata  = st_q.shreg[6];
                        st_d.bitcnt = st_q.bitcnt + 3'h1;
                        st_d.state  = rps_pkg::SER_LOW;
                    end else if (rd_valid) begin
                        rd_ready    = 1'b1;
                        st_d.shreg  = rd_data;
                        st_d.sdata  = rd_data[7];
                        st_d.bitcnt = 3'h0;
                        st_d.state  = rps_pkg::SER_LOW;
                    end else begin
                        st_d.sdata = 1'b0;
                        st_d.state = rps_pkg::SER_IDLE;
                    end
                end
            end
            default: begin
                st_d.state = rps_pkg::SER_IDLE;
            end
        endcase
        // Disable aborts the byte in flight
        if (!en) begin
            rd_ready   = 1'b0;
            st_d.sclk  = 1'b0;
            st_d.sdata = 1'b0;
            st_d.state = rps_pkg::SER_IDLE;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q       <= '0;
            st_q.fn    <= {rps_pkg::PIN_COUNT{rps_pkg::PIN_FN_RESET}};
            st_q.mtest <= rps_pkg::MDM_TEST_B_RESET;
            st_q.state <= rps_pkg::SER_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign pin_out   = st_q.pout;
    assign pin_oe    = st_q.poe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int HALF_I = rps_pkg::HALF_CYC; // Half period, cycles

    logic [8:0] hi_cnt_q; // Cycles clock has been high
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_q <= 9'h000;
        end else begin
            hi_cnt_q <= st_q.sclk ? hi_cnt_q + 9'h001 : 9'h000;
        end
    end

    sequence seq_load;
        st_q.state == rps_pkg::SER_IDLE && en && rd_valid;
    endsequence

    sequence seq_crc_in;
        en && tx_crc_valid && tx_auto_crc;
    endsequence

    AST_HIGH_HALF:
    assert property (@(posedge mclk) disable iff (!nrst || !en)
        $fell(st_q.sclk) |-> hi_cnt_q == 9'(HALF_I))
    else $error("sniffer clock high phase has wrong length");

    AST_LOW_HALF:
    assert property (@(posedge mclk) disable iff (!nrst || !en)
        $fell(st_q.sclk) && st_q.state == rps_pkg::SER_LOW |-> ##200 $rose(st_q.sclk))
    else $error("sniffer clock low phase has wrong length");

    AST_STABLE_RISE:
    assert property (@(posedge mclk) disable iff (!nrst)
        $rose(st_q.sclk) |-> $stable(st_q.sdata))
    else $error("sniffer data moved at rising clock");

    AST_MSB_FIRST:
    assert property (@(posedge mclk) disable iff (!nrst)
        seq_load |=> !st_q.sclk && st_q.sdata == $past(rd_data[7]))
    else $error("first bit is not the byte msb");

    AST_CRC_MARK:
    assert property (@(posedge mclk) disable iff (!nrst)
        seq_crc_in |-> wr_valid && wr_data == rps_pkg::CRC_MARK_BYTE)
    else $error("generated crc byte not replaced by marker");

    AST_TX_PASS:
    assert property (@(posedge mclk) disable iff (!nrst)
        en && tx_byte_valid && !tx_crc_valid |-> wr_valid && wr_data == tx_byte)
    else $error("transmit byte not captured unchanged");

    AST_RX_PASS:
    assert property (@(posedge mclk) disable iff (!nrst)
        en && rx_byte_valid && !tx_byte_valid && !tx_crc_valid
        |-> wr_valid && wr_data == rx_byte)
    else $error("receive byte not captured unchanged");

    AST_IDLE_QUIET:
    assert property (@(posedge mclk) disable iff (!nrst)
        !en |=> !st_q.sclk && !st_q.sdata)
    else $error("sniffer outputs active while disabled");

    AST_PIN0_CLK:
    assert property (@(posedge mclk) disable iff (!nrst)
        st_q.fn[0] == rps_pkg::FN_SNIFF_CLK && $stable(st_q.fn[0])
        |=> pin_oe[0] && pin_out[0] == $past(en && st_q.sclk))
    else $error("pin0 does not carry the gated sniffer clock");

endmodule : rps_sniffer

/* File: rps_capture.sv */
/*
 * Capture model of the far side: a shift receiver that samples the
 * sniffer data pin on each rising edge of the sniffer clock pin.
 * Assumes both pins are sampled on mclk, which is far faster than them.
 */
module rps_capture (
    input  wire logic        mclk,      // System clock
    input  wire logic        nrst,      // Async reset, active low
    input  wire logic        clr,       // Drop a partial byte
    input  wire logic        sclk,      // Sniffer clock pin
    input  wire logic        sdata,     // Sniffer data pin
    output logic      [7:0]  last_byte, // Last whole byte taken
    output logic      [15:0] byte_cnt,  // Whole bytes taken
    output logic      [15:0] period,    // Cycles between rising edges
    output logic             glitch     // Data moved while clock high
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        sclk_q;    // Clock pin one cycle back
    logic        sdata_q;   // Data pin one cycle back
    logic [6:0]  shift_q;   // Bits of the byte so far
    logic [2:0]  nbits_q;   // Bit count within the byte
    logic [15:0] cyc_q;     // Free cycle count
    logic [15:0] rise_q;    // Cycle of the last rising edge

    // -----------------------------------------------------------
    // Sampling on the rising clock edge
    // -----------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {sclk_q, sdata_q, shift_q, nbits_q, glitch} <= '0;
            {cyc_q, rise_q, byte_cnt, period, last_byte} <= '0;
        end else begin
            sclk_q  <= sclk;
            sdata_q <= sdata;
            cyc_q   <= cyc_q + 16'h0001;
            if (clr) begin
                nbits_q <= 3'h0;
            end else if (sclk && !sclk_q) begin
                shift_q <= {shift_q[5:0], sdata};
                nbits_q <= nbits_q + 3'h1;
                period  <= cyc_q - rise_q;
                rise_q  <= cyc_q;
                if (nbits_q == 3'h7) begin // First bit is the MSB
                    last_byte <= {shift_q, sdata};
                    byte_cnt  <= byte_cnt + 16'h0001;
                end
            end
            // Data must hold while the clock is high
            if (sclk && sclk_q && sdata !== sdata_q) begin
                glitch <= 1'b1;
            end
        end
    end
endmodule : rps_capture

/* File: tb.sv */
/*
 * Self-checking bench for the sniffer output: register access, pin
 * routing, transmit and receive streams, overflow and abort.
 * Assumes pin0 carries the sniffer clock and pin1 the sniffer data.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 0, nrst = 0, reg_we = 0, reg_re = 0, clr = 0;
    logic [6:0]  reg_addr = '0;
    logic [7:0]  reg_wdata = '0, tx_byte = '0, rx_byte = '0, reg_rdata;
    logic        tx_byte_valid = 0, tx_crc_valid = 0, tx_auto_crc = 0;
    logic        rx_byte_valid = 0, sfd = 0, sniff_ready, glitch;
    logic [5:0]  pin_out, pin_oe;
    logic [7:0]  last_byte;
    logic [15:0] byte_cnt, period;
    int          fails = 0, n_compared = 0, cycles = 0;

    rps_sniffer i_rps_sniffer (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_crc_valid(tx_crc_valid), .tx_auto_crc(tx_auto_crc),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .sfd(sfd),
        .pin_out(pin_out), .pin_oe(pin_oe), .sniff_ready(sniff_ready));
    rps_capture i_rps_capture (.mclk(mclk), .nrst(nrst), .clr(clr),
        .sclk(pin_out[0]), .sdata(pin_out[1]), .last_byte(last_byte),
        .byte_cnt(byte_cnt), .period(period), .glitch(glitch));

    // -----------------------------------------------------------
    // Clock and watchdog
    // -----------------------------------------------------------
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin // Tests need about 60000 cycles
            fails++;
            wrap_up();
        end
    end

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic step(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_wr(logic [6:0] a, logic [7:0] d);
        step();
        reg_addr = a; reg_wdata = d; reg_we = 1;
        step();
        reg_we = 0;
    endtask : reg_wr
    task automatic reg_rd(logic [6:0] a, logic [7:0] exp);
        step();
        reg_addr = a; reg_re = 1;
        step();
        reg_re = 0;
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask : reg_rd
    // Pulse one modem tap: 0 transmit, 1 generated CRC, 2 receive
    task automatic tap(int kind, logic [7:0] d);
        step();
        tx_byte = d; rx_byte = d;
        tx_byte_valid = (kind == 0); tx_crc_valid = (kind == 1);
        rx_byte_valid = (kind == 2);
        step();
        {tx_byte_valid, tx_crc_valid, rx_byte_valid} = '0;
    endtask : tap
    task automatic wait_byte(logic [7:0] exp);
        logic [15:0] n;
        int t;
        n = byte_cnt;
        t = 0;
        while (byte_cnt === n && t < 5000) begin
            step();
            t++;
        end
        chk("byte_cnt", n + 16'h0001, byte_cnt);
        chk("sniffed byte", {8'h00, exp}, {8'h00, last_byte});
    endtask : wait_byte
    task automatic done(string name);
        $display("test %s finished, %0d mismatches so far", name, fails);
    endtask : done
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        step(5);
        nrst = 1;
        // Reset values, unmapped place
        for (int i = 0; i < rps_pkg::PIN_COUNT; i++) begin
            reg_rd(rps_pkg::ADDR_PIN0_FN + 7'(i), rps_pkg::PIN_FN_RESET);
        end
        reg_rd(rps_pkg::ADDR_MDM_TEST_B, rps_pkg::MDM_TEST_B_RESET);
        reg_wr(7'h30, 8'hFF);
        reg_rd(7'h30, 8'h00);
        done("registers");
        // Pin routing while the sniffer is still off
        reg_wr(rps_pkg::ADDR_PIN0_FN, rps_pkg::FN_SNIFF_CLK);
        reg_wr(rps_pkg::ADDR_PIN0_FN + 7'h01, rps_pkg::FN_SNIFF_DATA);
        reg_wr(rps_pkg::ADDR_PIN0_FN + 7'h02, rps_pkg::FN_SFD);
        reg_wr(rps_pkg::ADDR_PIN0_FN + 7'h03, rps_pkg::FN_SNIFF_CLK);
        reg_rd(rps_pkg::ADDR_PIN0_FN + 7'h01, rps_pkg::FN_SNIFF_DATA);
        step(2);
        chk("pin_oe", 16'h000F, {10'h000, pin_oe});
        sfd = 1;
        step(3);
        chk("sfd pin", 16'h0001, {15'h0000, pin_out[2]});
        sfd = 0;
        tap(0, 8'hFF);
        step(1000);
        chk("byte_cnt off", 16'h0000, byte_cnt);
        chk("pins off", 16'h0000, {12'h000, pin_out[3:0]});
        done("routing");
        // Transmit with generated CRC, then receive
        reg_wr(rps_pkg::ADDR_MDM_TEST_B, 8'h04);
        reg_rd(rps_pkg::ADDR_MDM_TEST_B, 8'h04);
        tx_auto_crc = 1;
        tap(0, 8'hA5);
        tap(0, 8'h3C);
        tap(1, 8'h11);
        tap(1, 8'h22);
        tx_auto_crc = 0;
        tap(1, 8'h33);
        tap(2, 8'h12);
        tap(2, 8'hF0);
        wait_byte(8'hA5);
        wait_byte(8'h3C);
        chk("period", 16'(2 * rps_pkg::HALF_CYC), period);
        wait_byte(rps_pkg::CRC_MARK_BYTE);
        wait_byte(rps_pkg::CRC_MARK_BYTE);
        wait_byte(8'h12);
        wait_byte(8'hF0);
        step(1000);
        chk("idle count", 16'h0006, byte_cnt);
        chk("idle pins", 16'h0000, {14'h0000, pin_out[1:0]});
        done("stream");
        // Overflow: one byte in the shifter, eight buffered, one dropped
        for (int i = 0; i < 10; i++) begin
            step();
            rx_byte = 8'(8'h40 + i);
            rx_byte_valid = 1;
        end
        step();
        rx_byte_valid = 0;
        chk("sniff_ready", 16'h0000, {15'h0000, sniff_ready});
        for (int i = 0; i < 9; i++) begin
            wait_byte(8'(8'h40 + i));
        end
        step(4000);
        chk("after overflow", 16'h000F, byte_cnt);
        done("overflow");
        // Abort in mid-byte flushes the buffer
        tap(0, 8'hC3);
        tap(0, 8'h77);
        step(1000);
        reg_wr(rps_pkg::ADDR_MDM_TEST_B, 8'h00);
        step(3);
        chk("abort pins", 16'h0000, {14'h0000, pin_out[1:0]});
        clr = 1;
        step();
        clr = 0;
        reg_wr(rps_pkg::ADDR_MDM_TEST_B, 8'h04);
        tap(0, 8'h5A);
        wait_byte(8'h5A);
        chk("data held high", 16'h0000, {15'h0000, glitch});
        done("abort");
        wrap_up();
    end
endmodule : tb
